// *** core/dcl_defs.svh ***
// Constants for the decimator weight memory loader
`ifndef DCL_DEFS_SVH
`define DCL_DEFS_SVH

// Register addresses on the serial configuration port
`define DCL_ADDR_GLOBAL     8'h00
`define DCL_ADDR_FORMAT     8'h03
`define DCL_ADDR_PATH       8'h0a
`define DCL_ADDR_SHIFT      8'h1d
`define DCL_ADDR_PTR_ONE    8'h06
`define DCL_ADDR_PTR_BOTH   8'hc6
`define DCL_ADDR_DATA_ONE   8'h07
`define DCL_ADDR_DATA_BOTH  8'hc7

// Frame geometry
`define DCL_ADDR_BITS       8
`define DCL_REG_BITS        16
`define DCL_WORD_BITS       112
`define DCL_SHORT_FRAME     7'h18
`define DCL_LONG_FRAME      7'h78
`define DCL_BITCNT_W        7

// Weight layout
`define DCL_WEIGHT_BITS     14
`define DCL_LANES           8
`define DCL_LANE_LAST       3'h7
`define DCL_MEM_DEPTH       256
`define DCL_PTR_W           8

// Control fields
`define DCL_GLB_READ_BIT    0
`define DCL_GLB_TRIG_BIT    2
`define DCL_FMT_RES_HI      11
`define DCL_FMT_RES_LO      9
`define DCL_FMT_RES_16      3'h4
`define DCL_PATH_OFFS_BIT   0
`define DCL_PATH_MIX_BIT    2
`define DCL_PATH_SCALE_BIT  13
`define DCL_PATH_REMOD_BIT  14
`define DCL_SHF_ON_BIT      7
`define DCL_SHF_VAL_HI      6
`define DCL_SHF_VAL_LO      4
`define DCL_SHF_VAL_TEST    3'h6

// Frame marker delay: k = base + ratio + 1
`define DCL_MARK_BASE       7'h10
`define DCL_MARK_EXTRA      7'h01
`define DCL_SYNC_WORD       16'h5a5a

`endif

// *** core/dcl_pkg.sv ***
// Types shared by the decimator weight memory loader
package dcl_pkg;
    typedef enum logic [2:0] {
        DCL_RD_IDLE,
        DCL_RD_HEAD,
        DCL_RD_FWD,
        DCL_RD_REV,
        DCL_RD_TAIL
    } dcl_rd_state_t;
endpackage

// *** core/dcl_top.sv ***
// Decimator weight memory loader, weight test readout and frame marker timing
// Notes on behaviour
// - Alias pointer write updates both sub-units
// - One 112-bit serial write per word
// - Word splits into eight 14-bit weights
// - Weights are signed two's complement
// - Pointer increments after each word
// - Test mode streams weights to output
// - Ratio two: word0 odd, word1 even weights
// - Readout: zero, forward, mirrored, zero
// - After last weight replay in reverse
// - Sync latched on falling edge after rise
// - Marker starts 16 plus ratio plus one later
// - Memory holds 256 words, eight-bit pointer
// - New weights apply after trigger event
`include "dcl_defs.svh"
module dcl_top (
    // Sample clock and reset
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST_N,
    // Serial configuration port
    input  wire logic        I_SCLK,
    input  wire logic        I_SEN_N,
    input  wire logic        I_SDATA,
    output logic             O_SDOUT,
    // Transmit sync and block controls
    input  wire logic        I_TX_SYNC,
    input  wire logic        I_WEIGHT_TEST_MODE_ON,
    input  wire logic [5:0]  I_DECIMATION_RATIO,
    // Output sample stream
    output logic [15:0]      O_OUT_WORD,
    output logic             O_OUT_VALID,
    output logic             O_FRAME_MARK
);
    // Pin synchronisers
    logic [1:0] sclk_ff, sen_ff, sdat_ff;
    logic       sclk_d_ff, sync_neg_ff, sync_s2_ff, sync_d_ff;
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sclk_ff   <= 2'h0;
            sen_ff    <= 2'h3;
            sdat_ff   <= 2'h0;
            sclk_d_ff <= 1'b0;
        end else begin
            sclk_ff   <= {sclk_ff[0], I_SCLK};
            sen_ff    <= {sen_ff[0], I_SEN_N};
            sdat_ff   <= {sdat_ff[0], I_SDATA};
            sclk_d_ff <= sclk_ff[1];
        end
    end

    // Sync caught on the falling edge, then retimed to the rising edge
    always_ff @(negedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) sync_neg_ff <= 1'b0;
        else          sync_neg_ff <= I_TX_SYNC;
    end
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sync_s2_ff <= 1'b0;
            sync_d_ff  <= 1'b0;
        end else begin
            sync_s2_ff <= sync_neg_ff;
            sync_d_ff  <= sync_s2_ff;
        end
    end

    logic sclk_rise, sclk_fall, sen_act, sync_rise;
    assign sclk_rise = sclk_ff[1] & ~sclk_d_ff & ~sen_ff[1];
    assign sclk_fall = ~sclk_ff[1] & sclk_d_ff & ~sen_ff[1];
    assign sen_act   = ~sen_ff[1];
    assign sync_rise = sync_s2_ff & ~sync_d_ff;

    // Serial frame receiver: address first, then data, MSB first
    logic [`DCL_BITCNT_W-1:0]   bit_cnt_ff;
    logic [`DCL_ADDR_BITS-1:0]  addr_ff;
    logic [`DCL_WORD_BITS-1:0]  shift_ff;
    logic                       sen_d_ff;
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            bit_cnt_ff <= '0;
            addr_ff    <= '0;
            shift_ff   <= '0;
            sen_d_ff   <= 1'b0;
        end else begin
            sen_d_ff <= sen_act;
            if (!sen_act) begin
                bit_cnt_ff <= '0;
            end else if (sclk_rise) begin
                if (bit_cnt_ff < `DCL_BITCNT_W'(`DCL_ADDR_BITS)) addr_ff <= {addr_ff[6:0], sdat_ff[1]};
                else shift_ff <= {shift_ff[`DCL_WORD_BITS-2:0], sdat_ff[1]};
                if (bit_cnt_ff != `DCL_LONG_FRAME) bit_cnt_ff <= bit_cnt_ff + 7'h01;
            end
        end
    end

    // Commit at end of frame: control frames need exactly 24 bits, data frames 120 or more (the count stops at 120)
    logic frame_end, is_data, is_ptr, wr_short, wr_word;
    assign frame_end = sen_d_ff & ~sen_act;
    assign is_data   = (addr_ff == `DCL_ADDR_DATA_BOTH) || (addr_ff == `DCL_ADDR_DATA_ONE);
    assign is_ptr    = (addr_ff == `DCL_ADDR_PTR_BOTH) || (addr_ff == `DCL_ADDR_PTR_ONE);
    assign wr_short  = frame_end & ~is_data & (bit_cnt_ff == `DCL_SHORT_FRAME);
    assign wr_word   = frame_end & is_data & (bit_cnt_ff == `DCL_LONG_FRAME);

    // Plain control registers
    logic [15:0] glb_ff, fmt_ff, path_ff, shf_ff;
    logic        read_mode, trigger;
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            glb_ff  <= '0;
            fmt_ff  <= '0;
            path_ff <= '0;
            shf_ff  <= '0;
        end else begin
            // Manual trigger bit is self clearing so each write is one event
            glb_ff[`DCL_GLB_TRIG_BIT] <= 1'b0;
            if (wr_short) begin
                case (addr_ff)
                    `DCL_ADDR_GLOBAL: glb_ff  <= shift_ff[15:0];
                    `DCL_ADDR_FORMAT: fmt_ff  <= shift_ff[15:0];
                    `DCL_ADDR_PATH:   path_ff <= shift_ff[15:0];
                    `DCL_ADDR_SHIFT:  shf_ff  <= shift_ff[15:0];
                    default: ;
                endcase
            end
        end
    end
    assign read_mode = glb_ff[`DCL_GLB_READ_BIT];
    assign trigger   = sync_rise | glb_ff[`DCL_GLB_TRIG_BIT];

    // Word pointers of the two sub-units; the alias writes both
    logic [`DCL_PTR_W-1:0] ptr_a_ff, ptr_b_ff, load_base_ff, active_base_ff;
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            ptr_a_ff     <= '0;
            ptr_b_ff     <= '0;
            load_base_ff <= '0;
        end else if (wr_short && is_ptr) begin
            ptr_a_ff     <= shift_ff[`DCL_PTR_W-1:0];
            load_base_ff <= shift_ff[`DCL_PTR_W-1:0];
            if (addr_ff == `DCL_ADDR_PTR_BOTH) ptr_b_ff <= shift_ff[`DCL_PTR_W-1:0];
        end else if (wr_word) begin
            // Eight-bit pointer wraps across the 256 words
            ptr_a_ff <= ptr_a_ff + 8'h01;
            if (addr_ff == `DCL_ADDR_DATA_BOTH) ptr_b_ff <= ptr_b_ff + 8'h01;
        end
    end

    // Readout uses the base that was in force at the last trigger
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N)     active_base_ff <= '0;
        else if (trigger) active_base_ff <= load_base_ff;
    end

    // Register read back on the falling serial clock
    logic [15:0] rd_shift_ff, rd_val;
    always_comb begin
        case (addr_ff)
            `DCL_ADDR_GLOBAL:   rd_val = glb_ff;
            `DCL_ADDR_FORMAT:   rd_val = fmt_ff;
            `DCL_ADDR_PATH:     rd_val = path_ff;
            `DCL_ADDR_SHIFT:    rd_val = shf_ff;
            `DCL_ADDR_PTR_ONE,
            `DCL_ADDR_PTR_BOTH: rd_val = {8'h00, ptr_a_ff};
            default:            rd_val = 16'h0000;
        endcase
    end
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rd_shift_ff <= '0;
        end else if (sclk_fall && read_mode) begin
            if (bit_cnt_ff == `DCL_BITCNT_W'(`DCL_ADDR_BITS)) rd_shift_ff <= rd_val;
            else rd_shift_ff <= {rd_shift_ff[14:0], 1'b0};
        end else if (!sen_act) begin
            rd_shift_ff <= '0;
        end
    end
    assign O_SDOUT = rd_shift_ff[15];

    // Test readout walks blocks serpentine, then mirrors back
    dcl_pkg::dcl_rd_state_t st_ff;
    logic [8:0] pos_ff, last_pos;
    logic [5:0] ratio;
    logic       test_ok;
    assign ratio    = (I_DECIMATION_RATIO == 6'h00) ? 6'h01 : I_DECIMATION_RATIO;
    assign last_pos = {ratio, 3'h0} - 9'h001;
    assign test_ok  = I_WEIGHT_TEST_MODE_ON
                    & (fmt_ff[`DCL_FMT_RES_HI:`DCL_FMT_RES_LO] == `DCL_FMT_RES_16)
                    & path_ff[`DCL_PATH_OFFS_BIT] & path_ff[`DCL_PATH_MIX_BIT]
                    & path_ff[`DCL_PATH_SCALE_BIT] & path_ff[`DCL_PATH_REMOD_BIT]
                    & shf_ff[`DCL_SHF_ON_BIT]
                    & (shf_ff[`DCL_SHF_VAL_HI:`DCL_SHF_VAL_LO] == `DCL_SHF_VAL_TEST);

    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_ff  <= dcl_pkg::DCL_RD_IDLE;
            pos_ff <= '0;
        end else if (!test_ok) begin
            st_ff  <= dcl_pkg::DCL_RD_IDLE;
            pos_ff <= '0;
        end else begin
            case (st_ff)
                dcl_pkg::DCL_RD_IDLE: st_ff <= dcl_pkg::DCL_RD_HEAD;
                dcl_pkg::DCL_RD_HEAD: begin
                    st_ff  <= dcl_pkg::DCL_RD_FWD;
                    pos_ff <= '0;
                end
                dcl_pkg::DCL_RD_FWD: begin
                    if (pos_ff == last_pos) st_ff <= dcl_pkg::DCL_RD_REV;
                    else pos_ff <= pos_ff + 9'h001;
                end
                dcl_pkg::DCL_RD_REV: begin
                    if (pos_ff == 9'h000) st_ff <= dcl_pkg::DCL_RD_TAIL;
                    else pos_ff <= pos_ff - 9'h001;
                end
                dcl_pkg::DCL_RD_TAIL: st_ff <= dcl_pkg::DCL_RD_HEAD;
                default: st_ff <= dcl_pkg::DCL_RD_IDLE;
            endcase
        end
    end

    // Block j goes up in even blocks and down in odd ones
    logic [5:0]  blk;
    logic [2:0]  lane, lane_ff;
    logic [`DCL_PTR_W-1:0] rd_addr;
    logic [`DCL_WORD_BITS-1:0] rd_word;
    assign blk     = pos_ff[8:3];
    assign lane    = blk[0] ? (`DCL_LANE_LAST - pos_ff[2:0]) : pos_ff[2:0];
    assign rd_addr = active_base_ff + {2'h0, blk};

    dcl_weight_ram u_ram (
        .i_clk     (I_CLOCK),
        .i_wr_en   (wr_word),
        .i_wr_addr (ptr_a_ff),
        .i_wr_data (shift_ff),
        .i_rd_addr (rd_addr),
        .o_rd_data (rd_word)
    );

    // Split the word into eight lanes; lane n sits at bits 14n+13:14n
    logic [`DCL_WEIGHT_BITS-1:0] weights [0:`DCL_LANES-1];
    for (genvar g = 0; g < `DCL_LANES; g++) begin : g_lane
        assign weights[g] = rd_word[g*`DCL_WEIGHT_BITS +: `DCL_WEIGHT_BITS];
    end

    // Pipeline stage matches the one-cycle memory read
    logic smp_ff, zero_ff;
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            smp_ff  <= 1'b0;
            zero_ff <= 1'b0;
            lane_ff <= '0;
        end else begin
            smp_ff  <= (st_ff != dcl_pkg::DCL_RD_IDLE) & test_ok;
            zero_ff <= (st_ff == dcl_pkg::DCL_RD_HEAD) | (st_ff == dcl_pkg::DCL_RD_TAIL);
            lane_ff <= lane;
        end
    end

    // Frame marker delay: k periods after the latched sync edge
    logic [6:0] mark_k, mark_cnt_ff;
    logic       mark_run_ff, mark_now;
    assign mark_k   = `DCL_MARK_BASE + {1'b0, ratio} + `DCL_MARK_EXTRA;
    assign mark_now = mark_run_ff & (mark_cnt_ff == mark_k - 7'h01);
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            mark_run_ff <= 1'b0;
            mark_cnt_ff <= '0;
        end else if (sync_rise) begin
            mark_run_ff <= 1'b1;
            mark_cnt_ff <= '0;
        end else if (mark_now) begin
            mark_run_ff <= 1'b0;
        end else if (mark_run_ff) begin
            mark_cnt_ff <= mark_cnt_ff + 7'h01;
        end
    end

    // Output word register; the marker takes precedence over a sample
    logic [`DCL_WEIGHT_BITS-1:0] w_sel;
    assign w_sel = weights[lane_ff];
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_OUT_WORD   <= '0;
            O_OUT_VALID  <= 1'b0;
            O_FRAME_MARK <= 1'b0;
        end else begin
            O_FRAME_MARK <= mark_now;
            O_OUT_VALID  <= mark_now | smp_ff;
            if (mark_now)     O_OUT_WORD <= `DCL_SYNC_WORD;
            else if (!smp_ff || zero_ff) O_OUT_WORD <= 16'h0000;
            else O_OUT_WORD <= {{2{w_sel[13]}}, w_sel};
        end
    end

    // Helper: cycles since the latched sync edge
    logic [6:0] since_ff;
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N)        since_ff <= '0;
        else if (sync_rise)  since_ff <= 7'h01;
        else if (since_ff != 7'h7f) since_ff <= since_ff + 7'h01;
    end

    a_ptr_both_units: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (wr_short && addr_ff == `DCL_ADDR_PTR_BOTH) |=> (ptr_a_ff == ptr_b_ff && ptr_a_ff == $past(shift_ff[7:0])))
        else $error("alias pointer write did not reach both units");
    a_ptr_advance: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        wr_word |=> ptr_a_ff == $past(ptr_a_ff) + 8'h01)
        else $error("pointer did not advance after word");
    a_full_word_only: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (frame_end && is_data && bit_cnt_ff != `DCL_LONG_FRAME) |=> $stable(ptr_a_ff))
        else $error("short data frame moved the pointer");
    a_sign_extend: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (O_OUT_VALID && !O_FRAME_MARK) |-> O_OUT_WORD[15] == O_OUT_WORD[14] && O_OUT_WORD[14] == O_OUT_WORD[13])
        else $error("weight not sign extended");
    a_head_zero: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (st_ff == dcl_pkg::DCL_RD_HEAD && test_ok) |=> ##1 (O_FRAME_MARK || (O_OUT_VALID && O_OUT_WORD == 16'h0000)))
        else $error("readout did not open with zero");
    a_reverse_turn: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (st_ff == dcl_pkg::DCL_RD_FWD && pos_ff == last_pos && test_ok)
        |=> (st_ff == dcl_pkg::DCL_RD_REV && pos_ff == $past(pos_ff)))
        else $error("readout did not turn back at last weight");
    a_marker_delay: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        $rose(O_FRAME_MARK) |-> since_ff == mark_k + 7'h01)
        else $error("frame marker at wrong distance from sync");
    a_sync_edge: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        sync_rise |-> sync_s2_ff && !sync_d_ff && $past(sync_neg_ff))
        else $error("sync edge without falling edge capture");
    a_trigger_base: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        trigger |=> active_base_ff == $past(load_base_ff))
        else $error("trigger did not take the new base");
    a_test_gate: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (!test_ok ##1 !test_ok ##1 !test_ok) |-> (!O_OUT_VALID || O_FRAME_MARK))
        else $error("samples streamed without test settings");

    c_word_commit: cover property (@(posedge I_CLOCK) disable iff (!I_RST_N) wr_word);
    c_reverse: cover property (@(posedge I_CLOCK) disable iff (!I_RST_N) st_ff == dcl_pkg::DCL_RD_REV);
    c_marker: cover property (@(posedge I_CLOCK) disable iff (!I_RST_N) O_FRAME_MARK);
    c_manual_trig: cover property (@(posedge I_CLOCK) disable iff (!I_RST_N) glb_ff[`DCL_GLB_TRIG_BIT]);
endmodule

// *** core/dcl_weight_ram.sv ***
// Weight memory: 256 words of 112 bits, registered read data
`include "dcl_defs.svh"
module dcl_weight_ram (
    // Clock
    input  wire logic                        i_clk,
    // Write port
    input  wire logic                        i_wr_en,
    input  wire logic [`DCL_PTR_W-1:0]       i_wr_addr,
    input  wire logic [`DCL_WORD_BITS-1:0]   i_wr_data,
    // Read port
    input  wire logic [`DCL_PTR_W-1:0]       i_rd_addr,
    output logic      [`DCL_WORD_BITS-1:0]   o_rd_data
);
    logic [`DCL_WORD_BITS-1:0] mem [0:`DCL_MEM_DEPTH-1];

    // No reset on the array; contents are undefined until loaded
    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    // Read data out of a register
    always_ff @(posedge i_clk) begin
        o_rd_data <= mem[i_rd_addr];
    end
endmodule

// *** testbench/dcl_host_model.sv ***
// Host model driving the serial configuration port of the weight loader
module dcl_host_model (
    // Sample clock
    input  wire logic i_clk,
    // Serial port
    output logic      o_sclk,
    output logic      o_sen_n,
    output logic      o_sdata,
    input  wire logic i_sdout
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle port: frame closed, link clock parked low
    initial begin
        o_sclk  = 1'b0;
        o_sen_n = 1'b1;
        o_sdata = 1'b0;
    end

    // Four sample clocks per link phase give a 200 ns link period
    task automatic hold(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // One frame of n bits, MSB first; read-back sampled just before each fall
    task automatic xfer(input logic [127:0] bits, input int n, output logic [15:0] rd);
        rd = 16'h0000;
        o_sen_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            o_sdata = bits[i];
            hold(4);
            o_sclk = 1'b1;
            hold(4);
            rd = {rd[14:0], i_sdout};
            o_sclk = 1'b0;
        end
        // Released data line shows the inverse so a stale bit is never reused
        o_sdata = ~o_sdata;
        hold(4);
        o_sen_n = 1'b1;
        hold(8);
    endtask
endmodule

// *** testbench/test_dcl_top.sv ***
// Self-checking bench for the weight memory loader and test readout
module test_dcl_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk;
    logic         rst_n;
    logic         sclk;
    logic         sen_n;
    logic         sdata;
    logic         sdout;
    logic         tx_sync;
    logic         test_on;
    logic [5:0]   ratio;
    logic [15:0]  out_word;
    logic         out_valid;
    logic         frame_mark;
    logic [15:0]  rd;
    logic [15:0]  f;
    logic [15:0]  exp_seq [0:33];
    logic [111:0] word;
    int           fail_count;
    int           checks;
    int           n;

    dcl_top i_dut (
        .I_CLOCK               (clk),
        .I_RST_N               (rst_n),
        .I_SCLK                (sclk),
        .I_SEN_N               (sen_n),
        .I_SDATA               (sdata),
        .O_SDOUT               (sdout),
        .I_TX_SYNC             (tx_sync),
        .I_WEIGHT_TEST_MODE_ON (test_on),
        .I_DECIMATION_RATIO    (ratio),
        .O_OUT_WORD            (out_word),
        .O_OUT_VALID           (out_valid),
        .O_FRAME_MARK          (frame_mark)
    );

    dcl_host_model i_host (
        .i_clk   (clk),
        .o_sclk  (sclk),
        .o_sen_n (sen_n),
        .o_sdata (sdata),
        .i_sdout (sdout)
    );

    // 40 MHz sample clock, kept running through all loading
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Weight for index k; low indices come out negative to exercise sign
    function automatic logic [13:0] coef(input int k);
        coef = 14'(k * 613 - 4000);
    endfunction

    function automatic logic [15:0] sext(input logic [13:0] c);
        sext = {{2{c[13]}}, c};
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        i_host.xfer({104'h0, a, d}, 24, rd);
    endtask

    // A read frame still commits its data bits, so it carries the expected value back
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp, input string what);
        i_host.xfer({104'h0, a, exp}, 24, rd);
        chk(rd, exp, what);
    endtask

    // Bounded wait for the readout to start
    task automatic wait_valid;
        n = 0;
        while (out_valid !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 50) begin
                fail_count++;
                $display("unexpected at %0t: readout never started", $time);
                final_report;
            end
        end
    endtask

    // Main sequence: reset, load, read back, readout, marker timing
    initial begin
        rst_n = 1'b0;
        tx_sync = 1'b0;
        test_on = 1'b0;
        ratio = 6'h02;
        fail_count = 0;
        checks = 0;
        exp_seq[0] = 16'h0000;
        exp_seq[33] = 16'h0000;
        for (int p = 0; p < 16; p++) begin
            f = (p < 8) ? sext(coef(2 * p + 1)) : sext(coef(2 * (15 - p)));
            exp_seq[1 + p] = f;
            exp_seq[32 - p] = f;
        end
        repeat (16) @(negedge clk);
        chk(out_word, 16'h0000, "reset word");
        chk({13'h0, out_valid, frame_mark, sdout}, 16'h0000, "reset flags");
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        $display("test reset done");

        wr_reg(8'hc6, 16'h0005);
        for (int j = 0; j < 2; j++) begin
            for (int l = 0; l < 8; l++)
                word[14 * l +: 14] = coef(2 * (1 + l) - (1 + j));
            i_host.xfer({8'h0, 8'hc7, word}, 120, rd);
        end
        // 52 of the 112 data bits, then the frame closes: must be dropped
        i_host.xfer({68'h0, 8'hc7, word[111:60]}, 60, rd);
        wr_reg(8'h03, 16'h0800);
        wr_reg(8'h00, 16'h0001);
        rd_reg(8'h03, 16'h0800, "format readback");
        rd_reg(8'h55, 16'h0000, "unmapped read");
        rd_reg(8'hc6, 16'h0007, "pointer after words");
        wr_reg(8'h00, 16'h0000);
        // Reading the pointer rewrote the load base; set it back through the single-unit alias
        wr_reg(8'h06, 16'h0005);
        $display("test load done");

        wr_reg(8'h00, 16'h0004);
        wr_reg(8'h0a, 16'h6005);
        test_on = 1'b1;
        repeat (10) @(negedge clk);
        chk({15'h0, out_valid}, 16'h0000, "stream without shift setup");
        test_on = 1'b0;
        wr_reg(8'h1d, 16'h00e0);
        test_on = 1'b1;
        wait_valid;
        for (int p = 0; p < 34; p++) begin
            chk(out_word, exp_seq[p], "readout word");
            @(negedge clk);
        end
        test_on = 1'b0;
        repeat (4) @(negedge clk);
        chk({15'h0, out_valid}, 16'h0000, "stream after disable");
        $display("test readout done");

        // Latch edge, retime stage and output register add three to k
        for (int m = 2; m <= 5; m += 3) begin
            ratio = 6'(m);
            repeat (4) @(negedge clk);
            // Raised on a falling edge, so the latch takes it one falling edge later
            tx_sync <= 1'b1;
            n = 0;
            while (frame_mark !== 1'b1 && n < 60) begin
                @(negedge clk);
                n++;
            end
            chk(16'(n), 16'(16 + m + 1 + 3), "marker delay");
            chk(out_word, 16'h5a5a, "marker word");
            tx_sync <= 1'b0;
            repeat (40) @(negedge clk);
        end
        $display("test marker done");
        final_report;
    end
endmodule
